// >>> hdl/sep_eeprom.sv
// What this block does
// - Write-protect high blocks every memory write.
// - Pointer holds last accessed location plus one.
// - Read address acked, then pointer byte shifted.
// - Master nack ends read; device releases data.
// - Repeated start abandons write, keeps loaded pointer.
// - Master ack makes device send next byte.
// - Pointer advances after every byte operation.
// - Whole array readable in one sequential read.
// - Data line driven open-drain, low only.
// - Data changes only while clock is low.
// - Write-protect low allows normal reads and writes.
// - Write-protect never changes read behaviour.
// - Chip-select inputs are ignored completely.
// - Low supply flag disables all writes.
// - Respond only when upper nibble matches code.
// - No acknowledge while programming is busy.
// - First byte after write control loads pointer.
// - Acknowledge held low through ninth clock high.
`timescale 1ns/100ps
`default_nettype none
module sep_eeprom #(
    parameter int unsigned MEM_DEPTH = sep_pkg::MEM_DEPTH,
    parameter logic [3:0]  DEV_CODE  = sep_pkg::DEV_CODE
) (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe_o,
    input  wire logic       wp_i,
    input  wire logic       supply_low_i,
    input  wire logic       prog_busy_i,
    input  wire logic [2:0] unused_select_inputs_i
);
    import sep_pkg::*;
    localparam int unsigned AW = $clog2(MEM_DEPTH);

    logic [SYNC_N-1:0] raw, s1_r, s2_r, s3_r, q_r;
    logic              scl_d_r, sda_d_r, scl_q, sda_q, wp_q, low_q, busy_q;
    sep_state_t        st_r;
    logic [3:0]        bitcnt_r;
    logic [7:0]        shreg_r;
    logic [7:0]        txreg_r;
    logic              tx_on_r;
    logic              ack_r;
    logic              mack_r;
    logic [AW-1:0]     ptr_r;
    logic              fetch_pend_r;
    logic              rvalid_r;
    logic [7:0]        rdata;
    logic              scl_rise, scl_fall, start, stop, rx_st, dec, slot_end;
    logic              code_ok, ack_ok, rd_ack, mack_rise, fetch_req, fetch_go;
    logic              wr_byte, mem_we, ptr_load, tx_load, tx_shift, send_end;

    sep_stream_if #(.W(DATA_W)) fill_s ();
    sep_stream_if #(.W(DATA_W)) drain_s ();

    // The select inputs are deliberately left unread.
    assign raw = {prog_busy_i, supply_low_i, wp_i, sda_i, scl_i};

    // A pin value is accepted once the second and third stages agree.
    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                s1_r[i] <= SYNC_RST[i];
                s2_r[i] <= SYNC_RST[i];
                s3_r[i] <= SYNC_RST[i];
                q_r[i]  <= SYNC_RST[i];
            end else begin
                s1_r[i] <= raw[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i]) begin
                    q_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign scl_q  = q_r[SYN_SCL];
    assign sda_q  = q_r[SYN_SDA];
    assign wp_q   = q_r[SYN_WP];
    assign low_q  = q_r[SYN_LOW];
    assign busy_q = q_r[SYN_BUSY];

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_q;
            sda_d_r <= sda_q;
        end
    end

    assign scl_rise = scl_q & ~scl_d_r;
    assign scl_fall = ~scl_q & scl_d_r;
    assign start    = scl_q & scl_d_r & sda_d_r & ~sda_q;
    assign stop     = scl_q & scl_d_r & ~sda_d_r & sda_q;

    assign rx_st    = (st_r == ST_CTRL) || (st_r == ST_WORD) || (st_r == ST_WDATA);
    assign dec      = rx_st && scl_fall && (bitcnt_r == CNT_BYTE);
    assign slot_end = rx_st && scl_fall && (bitcnt_r == CNT_ACK);
    assign code_ok  = (shreg_r[CODE_MSB:CODE_LSB] == DEV_CODE);
    assign ack_ok   = !busy_q && ((st_r != ST_CTRL) || code_ok);
    assign rd_ack   = dec && (st_r == ST_CTRL) && ack_ok && shreg_r[RW_POS];
    assign mack_rise = (st_r == ST_MACK) && scl_rise;
    assign fetch_req = rd_ack || (mack_rise && !sda_q);
    assign fetch_go = (fetch_req || fetch_pend_r) && fill_s.ready && !rvalid_r
                      && !start && !stop;
    assign wr_byte  = dec && (st_r == ST_WDATA) && ack_ok;
    assign mem_we   = wr_byte && !wp_q && !low_q;
    assign ptr_load = dec && (st_r == ST_WORD) && ack_ok;
    assign tx_load  = (slot_end && (st_r == ST_CTRL) && ack_r && shreg_r[RW_POS])
                      || ((st_r == ST_MACK) && scl_fall && mack_r);
    assign tx_shift = (st_r == ST_SEND) && scl_fall && (bitcnt_r != CNT_TX_LAST);
    assign send_end = (st_r == ST_SEND) && scl_fall && (bitcnt_r == CNT_TX_LAST);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r     <= ST_IDLE;
            bitcnt_r <= '0;
        end else if (start) begin
            st_r     <= ST_CTRL;
            bitcnt_r <= '0;
        end else if (stop) begin
            st_r     <= ST_IDLE;
            bitcnt_r <= '0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    bitcnt_r <= '0;
                end
                ST_CTRL, ST_WORD, ST_WDATA: begin
                    if (scl_rise && bitcnt_r < CNT_BYTE) begin
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (dec) begin
                        bitcnt_r <= CNT_ACK;
                    end else if (slot_end) begin
                        bitcnt_r <= '0;
                        if (!ack_r) begin
                            st_r <= ST_IDLE;
                        end else if (st_r == ST_CTRL) begin
                            st_r <= shreg_r[RW_POS] ? ST_SEND : ST_WORD;
                        end else begin
                            st_r <= ST_WDATA;
                        end
                    end
                end
                ST_SEND: begin
                    if (send_end) begin
                        st_r     <= ST_MACK;
                        bitcnt_r <= '0;
                    end else if (scl_fall) begin
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                end
                ST_MACK: begin
                    if (scl_fall) begin
                        st_r     <= mack_r ? ST_SEND : ST_IDLE;
                        bitcnt_r <= '0;
                    end
                end
                default: begin
                    st_r     <= ST_IDLE;
                    bitcnt_r <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shreg_r <= '0;
        end else if (rx_st && scl_rise && bitcnt_r < CNT_BYTE) begin
            shreg_r <= {shreg_r[6:0], sda_q};
        end
    end

    // The acknowledge is driven from the eighth falling edge to the ninth.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
        end else if (start || stop) begin
            ack_r <= 1'b0;
        end else if (dec) begin
            ack_r <= ack_ok;
        end else if (slot_end) begin
            ack_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mack_r <= 1'b0;
        end else if (mack_rise) begin
            mack_r <= ~sda_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            txreg_r <= IDLE_BYTE;
            tx_on_r <= 1'b0;
        end else if (start || stop) begin
            txreg_r <= IDLE_BYTE;
            tx_on_r <= 1'b0;
        end else if (tx_load) begin
            txreg_r <= drain_s.valid ? drain_s.data : IDLE_BYTE;
            tx_on_r <= 1'b1;
        end else if (tx_shift) begin
            txreg_r <= {txreg_r[6:0], 1'b1};
        end else if (send_end) begin
            txreg_r <= IDLE_BYTE;
            tx_on_r <= 1'b0;
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = ack_r || (tx_on_r && !txreg_r[7]);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr_r <= '0;
        end else if (ptr_load) begin
            ptr_r <= shreg_r[AW-1:0];
        end else if (wr_byte || fetch_go) begin
            ptr_r <= ptr_r + AW'(1);
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fetch_pend_r <= 1'b0;
            rvalid_r     <= 1'b0;
        end else begin
            rvalid_r <= fetch_go;
            if (start || stop || fetch_go) begin
                fetch_pend_r <= 1'b0;
            end else if (fetch_req) begin
                fetch_pend_r <= 1'b1;
            end
        end
    end

    sep_mem #(.DEPTH(MEM_DEPTH), .W(DATA_W), .AW(AW)) u_mem (
        .sys_clk_i (sys_clk_i),
        .we_i      (mem_we),
        .waddr_i   (ptr_r),
        .wdata_i   (shreg_r),
        .re_i      (fetch_go),
        .raddr_i   (ptr_r),
        .rdata_o   (rdata)
    );

    assign fill_s.valid  = rvalid_r;
    assign fill_s.data   = rdata;
    assign drain_s.ready = tx_load;

    sep_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .flush_i   (start || stop),
        .in_s      (fill_s.snk),
        .out_s     (drain_s.src)
    );

    property p_wp_block;
        @(posedge sys_clk_i) disable iff (!resetn_i) mem_we |-> !wp_q;
    endproperty
    a_wp_block: assert property (p_wp_block)
        else $error("Write with protect high.");
    property p_low_block;
        @(posedge sys_clk_i) disable iff (!resetn_i) mem_we |-> !low_q && !busy_q;
    endproperty
    a_low_block: assert property (p_low_block)
        else $error("Write with low supply.");
    property p_busy_noack;
        @(posedge sys_clk_i) disable iff (!resetn_i) $rose(ack_r) |-> !$past(busy_q);
    endproperty
    a_busy_noack: assert property (p_busy_noack)
        else $error("Acknowledge while busy.");
    property p_code_match;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            ($rose(ack_r) && st_r == ST_CTRL) |-> $past(shreg_r[7:4]) == DEV_CODE;
    endproperty
    a_code_match: assert property (p_code_match)
        else $error("Acknowledged foreign code.");
    property p_oe_scl_low;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            $changed(sda_oe_o) |-> !$past(scl_q) || $past(start) || $past(stop);
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("Data changed while clock high.");
    property p_ptr_inc;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (fetch_go && !ptr_load) |=> ptr_r == $past(ptr_r) + AW'(1);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc)
        else $error("Pointer not advanced.");
    property p_next_byte;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (st_r == ST_MACK && scl_fall && mack_r && !start && !stop) |=> st_r == ST_SEND;
    endproperty
    a_next_byte: assert property (p_next_byte)
        else $error("No next byte after ack.");
    property p_nack_release;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (st_r == ST_MACK && scl_fall && !mack_r) |=> (!sda_oe_o)[*4];
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("Data driven after nack.");
    property p_read_send;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (slot_end && st_r == ST_CTRL && ack_r && shreg_r[RW_POS] && !start && !stop)
            |=> st_r == ST_SEND && tx_on_r;
    endproperty
    a_read_send: assert property (p_read_send)
        else $error("Read not started after ack.");
    property p_ack_hold;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (ack_r && scl_rise && !start && !stop) |=> ack_r[*2];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("Acknowledge dropped in high phase.");
    property p_restart_keep;
        @(posedge sys_clk_i) disable iff (!resetn_i)
            (start && !ptr_load && !wr_byte) |=> st_r == ST_CTRL && ptr_r == $past(ptr_r);
    endproperty
    a_restart_keep: assert property (p_restart_keep)
        else $error("Repeated start lost pointer.");
endmodule : sep_eeprom
`default_nettype wire

// >>> hdl/sep_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sep_fifo #(
    parameter int unsigned W     = sep_pkg::DATA_W,
    parameter int unsigned DEPTH = sep_pkg::FIFO_DEPTH
) (
    input  wire logic     sys_clk_i,
    input  wire logic     resetn_i,
    input  wire logic     flush_i,
    sep_stream_if.snk     in_s,
    sep_stream_if.src     out_s
);
    import sep_pkg::*;

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] slot_r [DEPTH];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [PW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_s.ready  = (cnt_r != (PW+1)'(DEPTH));
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data  = slot_r[rd_r];
    assign push        = in_s.valid & in_s.ready & ~flush_i;
    assign pop         = out_s.valid & out_s.ready & ~flush_i;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            slot_r[wr_r] <= in_s.data;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else if (flush_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + PW'(1);
            end
            if (pop) begin
                rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + PW'(1);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + (PW+1)'(1);
            end else if (pop && !push) begin
                cnt_r <= cnt_r - (PW+1)'(1);
            end
        end
    end
endmodule : sep_fifo
`default_nettype wire

// >>> hdl/sep_mem.sv
`timescale 1ns/100ps
`default_nettype none
module sep_mem #(
    parameter int unsigned DEPTH = sep_pkg::MEM_DEPTH,
    parameter int unsigned W     = sep_pkg::DATA_W,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    input  wire logic          sys_clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    input  wire logic          re_i,
    input  wire logic [AW-1:0] raddr_i,
    output var  logic [W-1:0]  rdata_o
);
    import sep_pkg::*;

    logic [W-1:0] cell_r [DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            cell_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (re_i) begin
            rdata_o <= cell_r[raddr_i];
        end
    end
endmodule : sep_mem
`default_nettype wire

// >>> inc/sep_pkg.sv
`default_nettype none
package sep_pkg;
    localparam int unsigned  DATA_W       = 8;
    localparam int unsigned  MEM_DEPTH    = 256;
    localparam int unsigned  FIFO_DEPTH   = 2;
    // Device-type code value is arbitrary.
    localparam logic [3:0]   DEV_CODE     = 4'h5;
    localparam int unsigned  CODE_MSB     = 7;
    localparam int unsigned  CODE_LSB     = 4;
    localparam int unsigned  RW_POS       = 0;
    localparam logic [3:0]   CNT_BYTE     = 4'h8;
    localparam logic [3:0]   CNT_ACK      = 4'h9;
    localparam logic [3:0]   CNT_TX_LAST  = 4'h7;
    localparam logic [7:0]   IDLE_BYTE    = 8'hff;
    localparam int unsigned  SYNC_N       = 5;
    localparam int unsigned  SYN_SCL      = 0;
    localparam int unsigned  SYN_SDA      = 1;
    localparam int unsigned  SYN_WP       = 2;
    localparam int unsigned  SYN_LOW      = 3;
    localparam int unsigned  SYN_BUSY     = 4;
    localparam logic [4:0]   SYNC_RST     = 5'h03;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CTRL,
        ST_WORD,
        ST_WDATA,
        ST_SEND,
        ST_MACK
    } sep_state_t;
endpackage : sep_pkg
`default_nettype wire

// >>> inc/sep_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sep_stream_if #(parameter int unsigned W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sep_stream_if
`default_nettype wire

// >>> tb/sep_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module sep_bus_master (
    input  wire logic       sda_i,
    input  wire logic       slow_i,
    output var  logic       scl_o,
    output var  logic       sda_low_o,
    output var  logic       res_stb_o,
    output var  logic [7:0] res_data_o
);
    logic [7:0] rx;
    logic       ack;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        res_stb_o = 1'b0;
        res_data_o = 8'h00;
    end
    // Slow mode stretches the low phase so that the device has to wait on us.
    task automatic bit_xfer(input logic b, output logic s);
        #100;
        sda_low_o = ~b;
        #(slow_i ? 1200 : 400);
        scl_o = 1'b1;
        #280;
        s = sda_i;
        #20;
        scl_o = 1'b0;
    endtask : bit_xfer
    task automatic report(input logic [7:0] v);
        res_data_o = v;
        res_stb_o = 1'b1;
        // A whole clock period keeps every pin change at the same offset from the edge.
        #100;
        res_stb_o = 1'b0;
    endtask : report
    // Works from idle and as a repeated start after an acknowledge slot.
    task automatic start();
        #100;
        sda_low_o = 1'b0;
        #600;
        scl_o = 1'b1;
        #300;
        sda_low_o = 1'b1;
        #300;
        scl_o = 1'b0;
    endtask : start
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], rx[i]);
        end
        bit_xfer(1'b1, ack);
        report({7'h00, ack});
    endtask : send
    // An acknowledge asks for the next byte; a release ends the read.
    task automatic recv(input logic last);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, rx[i]);
        end
        bit_xfer(last, ack);
        report(rx);
    endtask : recv
    task automatic stop();
        #100;
        sda_low_o = 1'b1;
        #400;
        scl_o = 1'b1;
        #300;
        sda_low_o = 1'b0;
        #600;
    endtask : stop
endmodule : sep_bus_master
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sep_pkg::*;
    localparam int unsigned DEPTH = 128;
    logic        sys_clk_i  = 1'b0;
    logic        resetn_i   = 1'b0;
    logic        wp         = 1'b0;
    logic        supply_low = 1'b0;
    logic        busy       = 1'b0;
    logic        slow       = 1'b0;
    logic [2:0]  sel        = 3'h0;
    logic [31:0] seed       = 32'hee44;
    logic        scl;
    logic        m_low;
    logic        sda_o;
    logic        sda_oe;
    logic        res_stb;
    logic [7:0]  res_data;
    wire         sda_line;
    logic [7:0]  ref_mem [DEPTH];
    logic [7:0]  exp_q [$];
    logic [6:0]  ptr;
    int          n_fail     = 0;
    int          checked    = 0;
    int          cyc        = 0;

    assign sda_line = !(m_low || (sda_oe && !sda_o));
    always #50 sys_clk_i = ~sys_clk_i;

    sep_eeprom #(.MEM_DEPTH(DEPTH), .DEV_CODE(DEV_CODE)) i_sep_eeprom (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .wp_i(wp), .supply_low_i(supply_low),
        .prog_busy_i(busy), .unused_select_inputs_i(sel));
    sep_bus_master i_sep_bus_master (
        .sda_i(sda_line), .slow_i(slow), .scl_o(scl), .sda_low_o(m_low),
        .res_stb_o(res_stb), .res_data_o(res_data));

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic summarize();
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic pins(input logic w, input logic s, input logic b);
        @(posedge sys_clk_i);
        #10;
        wp = w;
        supply_low = s;
        busy = b;
    endtask : pins
    task automatic w_byte(input logic [7:0] b, input logic a);
        exp_q.push_back({7'h00, a});
        i_sep_bus_master.send(b);
    endtask : w_byte
    task automatic r_byte(input logic last);
        exp_q.push_back(ref_mem[ptr]);
        ptr = ptr + 7'h01;
        i_sep_bus_master.recv(last);
    endtask : r_byte
    // Don't-care bits of the control byte and the select pins are random.
    task automatic ctrl(input logic [3:0] code, input logic rd, input logic a);
        logic [7:0] r;
        r = rnd();
        @(posedge sys_clk_i);
        #10;
        sel = r[2:0];
        i_sep_bus_master.start();
        w_byte({code, r[5:3], rd}, a);
    endtask : ctrl
    task automatic set_addr(input logic [7:0] a);
        ctrl(DEV_CODE, 1'b0, 1'b0);
        w_byte(a, 1'b0);
        ptr = a[6:0];
    endtask : set_addr
    task automatic rd_seq(input int n);
        ctrl(DEV_CODE, 1'b1, 1'b0);
        for (int i = 1; i <= n; i++) begin
            r_byte(i == n);
        end
        i_sep_bus_master.stop();
        check({7'h00, sda_oe}, 8'h00, "data line held after stop");
    endtask : rd_seq
    task automatic wr(input logic [7:0] a, input int n, input logic keep);
        logic [7:0] d;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            d = rnd();
            w_byte(d, 1'b0);
            if (keep) begin
                ref_mem[ptr] = d;
            end
            ptr = ptr + 7'h01;
        end
        i_sep_bus_master.stop();
    endtask : wr

    always @(posedge res_stb) begin
        if (exp_q.size() == 0) begin
            check(8'h00, 8'h01, "unexpected result");
        end else begin
            check(res_data, exp_q.pop_front(), "bus result");
        end
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            check(8'h00, 8'h01, "timeout");
            summarize();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk_i);
        #10;
        resetn_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        // High word-address bit is dropped; the writes wrap past the top.
        wr(8'hfe, 5, 1'b1);
        set_addr(8'h7e);
        slow = 1'b1;
        rd_seq(4);
        slow = 1'b0;
        rd_seq(1);
        for (int k = 0; k < 2; k++) begin
            pins(k == 0, k == 1, 1'b0);
            wr(8'h00, 1, 1'b0);
            rd_seq(1);
            set_addr(8'h00);
            rd_seq(1);
        end
        pins(1'b0, 1'b0, 1'b1);
        ctrl(DEV_CODE, 1'b1, 1'b1);
        i_sep_bus_master.stop();
        pins(1'b0, 1'b0, 1'b0);
        ctrl(DEV_CODE ^ 4'h1, 1'b0, 1'b1);
        i_sep_bus_master.stop();
        rd_seq(2);
        repeat (20) @(posedge sys_clk_i);
        check(exp_q.size() == 0, 8'h01, "results missing");
        summarize();
    end
endmodule : testbench
`default_nettype wire
